/* hdl/clk_divider.sv */
// system clock divider: divides oscillator ticks by 2, 4, 8 or 16
// assumes osc_tick is a one-cycle pulse per oscillator period on the core clock
`timescale 1ns/1ps
module clk_divider
    import clkgen_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control side
    div_if.div dv
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [1:0] ratio_reg;
    logic [1:0] ratio_next;
    logic clk_reg;
    logic clk_next;
    logic tick_reg;
    logic tick_next;

    always_comb begin
        cnt_next = cnt_reg;
        ratio_next = ratio_reg;
        clk_next = clk_reg;
        tick_next = 1'b0;
        if (dv.osc_tick) begin
            if ({1'b0, cnt_reg} == div_period(ratio_reg) - 5'd1) begin
                // period boundary: only here may the ratio change
                cnt_next = 4'd0;
                ratio_next = dv.ratio_req;
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 4'd1;
            end
            clk_next = ({1'b0, cnt_next} < (div_period(ratio_next) >> 1));
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // start at the period end so the first oscillator tick opens a full period with a tick
            cnt_reg <= 4'(div_period(RATIO_DIV16) - 5'd1);
            ratio_reg <= RATIO_DIV16;
            clk_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            ratio_reg <= ratio_next;
            clk_reg <= clk_next;
            tick_reg <= tick_next;
        end
    end

    assign dv.ratio_cur = ratio_reg;
    assign dv.change_busy = (dv.ratio_req != ratio_reg);
    assign dv.sys_clk = clk_reg;
    assign dv.sys_tick = tick_reg;
endmodule

/* hdl/clock_generator.sv */
// system clock generator: oscillator source select, stop mode, wake-up stabilization, divider control
// assumes oscillator and wake pins are asynchronous, interrupt mask levels come from core-clock logic
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module clock_generator
    import clkgen_pkg::*;
#(
    parameter int STAB_UNIT_CYCLES = STAB_UNIT_CYC
)
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // axi4-lite write address
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // axi4-lite write data
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // axi4-lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // axi4-lite read
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // oscillator pins
    input wire logic OSC_INPUT_PRIMARY,
    input wire logic OSC_INPUT_SECONDARY,
    output logic OSC_AMP_EN,
    // wake sources
    input wire logic NMI_IN,
    input wire logic EXT_IRQ_FOUR,
    input wire logic EXT_IRQ_FIVE,
    input wire logic IRQ_FOUR_MASKED,
    input wire logic IRQ_FOUR_MACRO_SVC,
    input wire logic IRQ_FIVE_MASKED,
    input wire logic IRQ_FIVE_MACRO_SVC,
    // system clock and status
    output logic SYS_CLK,
    output logic SYS_CLK_TICK,
    output logic EXT_CLOCK_MODE,
    output logic STOP_ACTIVE,
    output logic STABILIZING
);
    div_if dv();

    // address decode shared by read and write
    function automatic logic [1:0] reg_sel(input logic [7:0] addr);
        case (addr)
            ADDR_STBY: reg_sel = SEL_STBY;
            ADDR_STAB: reg_sel = SEL_STAB;
            ADDR_STAT: reg_sel = SEL_STAT;
            default: reg_sel = SEL_NONE;
        endcase
    endfunction

    // pin synchronisers
    logic [PIN_N-1:0] pin_meta_reg;
    logic [PIN_N-1:0] pin_sync_reg;
    logic [PIN_N-1:0] pin_prev_reg;
    logic [PIN_N-1:0] pin_meta_next;
    logic [PIN_N-1:0] pin_sync_next;
    logic [PIN_N-1:0] pin_prev_next;
    logic [PIN_N-1:0] pin_rise;

    always_comb begin
        pin_meta_next = {EXT_IRQ_FIVE, EXT_IRQ_FOUR, NMI_IN, OSC_INPUT_SECONDARY, OSC_INPUT_PRIMARY};
        pin_sync_next = pin_meta_reg;
        pin_prev_next = pin_sync_reg;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
            pin_prev_reg <= '0;
        end else begin
            pin_meta_reg <= pin_meta_next;
            pin_sync_reg <= pin_sync_next;
            pin_prev_reg <= pin_prev_next;
        end
    end

    assign pin_rise = pin_sync_reg & ~pin_prev_reg;

    // axi write channel
    logic aw_full_reg;
    logic aw_full_next;
    logic [7:0] aw_addr_reg;
    logic [7:0] aw_addr_next;
    logic w_full_reg;
    logic w_full_next;
    logic [7:0] w_data_reg;
    logic [7:0] w_data_next;
    logic w_strb_reg;
    logic w_strb_next;
    logic bvalid_reg;
    logic bvalid_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;
    logic wr_fire;
    logic [1:0] wr_sel;

    assign S_AXI_AWREADY = !aw_full_reg;
    assign S_AXI_WREADY = !w_full_reg;
    assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_sel = reg_sel(aw_addr_reg);

    always_comb begin
        aw_full_next = aw_full_reg;
        aw_addr_next = aw_addr_reg;
        w_full_next = w_full_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (bvalid_reg && S_AXI_BREADY) begin
            bvalid_next = 1'b0;
        end
        if (wr_fire) begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_full_next = 1'b1;
            aw_addr_next = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_full_next = 1'b1;
            w_data_next = S_AXI_WDATA[7:0];
            w_strb_next = S_AXI_WSTRB[0];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_full_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_strb_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            aw_full_reg <= aw_full_next;
            aw_addr_reg <= aw_addr_next;
            w_full_reg <= w_full_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
        end
    end

    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;

    // control registers and oscillator state
    logic [7:0] stby_reg;
    logic [7:0] stby_next;
    logic [7:0] stab_reg;
    logic [7:0] stab_next;
    osc_state_e state_reg;
    osc_state_e state_next;
    logic [STAB_CNT_W-1:0] stab_cnt_reg;
    logic [STAB_CNT_W-1:0] stab_cnt_next;
    logic amp_en_reg;
    logic amp_en_next;
    logic wake;
    logic external_clock_select;
    logic [STAB_CNT_W-1:0] stab_len;

    assign external_clock_select = stab_reg[STAB_EXTERNAL_CLOCK_SELECT_BIT];
    assign wake = pin_rise[PIN_NMI]
        || (pin_rise[PIN_IRQ4] && !IRQ_FOUR_MASKED && !IRQ_FOUR_MACRO_SVC)
        || (pin_rise[PIN_IRQ5] && !IRQ_FIVE_MASKED && !IRQ_FIVE_MACRO_SVC);
    assign stab_len = external_clock_select ? STAB_CNT_W'(STAB_EXT_CYC)
        : STAB_CNT_W'(STAB_UNIT_CYCLES) << stab_reg[STAB_SEL_HI:STAB_SEL_LO];

    always_comb begin
        stby_next = stby_reg;
        stab_next = stab_reg;
        state_next = state_reg;
        stab_cnt_next = stab_cnt_reg;
        if (wr_fire && w_strb_reg && wr_sel == SEL_STBY) begin
            stby_next = w_data_reg;
        end
        if (wr_fire && w_strb_reg && wr_sel == SEL_STAB) begin
            stab_next = w_data_reg;
        end
        case (state_reg)
            RUN: begin
                if (wr_fire && w_strb_reg && wr_sel == SEL_STBY && w_data_reg[STBY_STOP_BIT]) begin
                    state_next = STOPPED;
                end
            end
            STOPPED: begin
                if (wake) begin
                    state_next = STABILIZE;
                    stab_cnt_next = stab_len;
                    stby_next[STBY_STOP_BIT] = 1'b0;
                end
            end
            STABILIZE: begin
                if (stab_cnt_reg <= STAB_CNT_W'(1)) begin
                    state_next = RUN;
                end else begin
                    stab_cnt_next = stab_cnt_reg - STAB_CNT_W'(1);
                end
            end
            default: begin
                state_next = RUN;
            end
        endcase
        amp_en_next = !stab_next[STAB_EXTERNAL_CLOCK_SELECT_BIT] && state_next != STOPPED;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            stby_reg <= STBY_RESET;
            stab_reg <= STAB_RESET;
            state_reg <= RUN;
            stab_cnt_reg <= '0;
            amp_en_reg <= 1'b1;
        end else begin
            stby_reg <= stby_next;
            stab_reg <= stab_next;
            state_reg <= state_next;
            stab_cnt_reg <= stab_cnt_next;
            amp_en_reg <= amp_en_next;
        end
    end

    // oscillator tick to the divider, gated outside run
    assign dv.osc_tick = (state_reg == RUN)
        && (external_clock_select ? pin_rise[PIN_X2] : pin_rise[PIN_X1]);
    assign dv.ratio_req = stby_reg[STBY_RATIO_HI:STBY_RATIO_LO];

    clk_divider u_div (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .dv(dv)
    );

    // axi read channel
    logic rvalid_reg;
    logic rvalid_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;
    logic [7:0] status;

    always_comb begin
        status = 8'h00;
        status[STAT_STOP_BIT] = (state_reg == STOPPED);
        status[STAT_STAB_BIT] = (state_reg == STABILIZE);
        status[STAT_BUSY_BIT] = dv.change_busy;
        status[STAT_AMP_BIT] = amp_en_reg;
        status[STAT_RATIO_HI:STAT_RATIO_LO] = dv.ratio_cur;
    end

    assign S_AXI_ARREADY = !rvalid_reg;

    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && S_AXI_RREADY) begin
            rvalid_next = 1'b0;
        end
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            case (reg_sel(S_AXI_ARADDR))
                SEL_STBY: rdata_next = stby_reg;
                SEL_STAB: rdata_next = stab_reg;
                SEL_STAT: rdata_next = status;
                default: begin
                    rdata_next = 8'h00;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 8'h00;
            rresp_reg <= RESP_OKAY;
        end else begin
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RDATA = {24'h00_0000, rdata_reg};
    assign S_AXI_RRESP = rresp_reg;

    // outputs; system clock fans out to cpu, watchdog, filter, serial, converter, pwm, irq, bus
    assign SYS_CLK = dv.sys_clk;
    assign SYS_CLK_TICK = dv.sys_tick;
    assign OSC_AMP_EN = amp_en_reg;
    assign EXT_CLOCK_MODE = external_clock_select;
    assign STOP_ACTIVE = (state_reg == STOPPED);
    assign STABILIZING = (state_reg == STABILIZE);
endmodule

/* shared/clkgen_pkg.sv */
// register map, field positions, reset values, timing counts and states of the clock generator
// assumes a single core clock at 125 MHz and an AXI4-Lite register port
package clkgen_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_STBY = 8'h00;
    localparam logic [7:0] ADDR_STAB = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    // reset values
    localparam logic [7:0] STBY_RESET = 8'h30;
    localparam logic [7:0] STAB_RESET = 8'h00;
    localparam logic [1:0] RATIO_DIV16 = 2'b11;
    // standby control fields
    localparam int STBY_STOP_BIT = 1;
    localparam int STBY_RATIO_LO = 4;
    localparam int STBY_RATIO_HI = 5;
    // stabilization time fields
    localparam int STAB_SEL_LO = 0;
    localparam int STAB_SEL_HI = 2;
    localparam int STAB_EXTERNAL_CLOCK_SELECT_BIT = 7;
    // status fields
    localparam int STAT_STOP_BIT = 0;
    localparam int STAT_STAB_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam int STAT_AMP_BIT = 3;
    localparam int STAT_RATIO_LO = 4;
    localparam int STAT_RATIO_HI = 5;
    // register select codes
    localparam logic [1:0] SEL_NONE = 2'd0;
    localparam logic [1:0] SEL_STBY = 2'd1;
    localparam logic [1:0] SEL_STAB = 2'd2;
    localparam logic [1:0] SEL_STAT = 2'd3;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // timing
    localparam int CORE_CLK_MHZ = 125;
    localparam int STAB_UNIT_NS = 2048;
    localparam int STAB_UNIT_CYC = (STAB_UNIT_NS * CORE_CLK_MHZ) / 1000;
    localparam int STAB_EXT_NS = 128;
    localparam int STAB_EXT_CYC = (STAB_EXT_NS * CORE_CLK_MHZ) / 1000;
    localparam int STAB_CNT_W = 24;
    // worst-case ratio change, in oscillator periods, per previous ratio
    localparam int CHG_MAX_DIV2 = 22;
    localparam int CHG_MAX_DIV4 = 24;
    localparam int CHG_MAX_DIV8 = 16;
    localparam int CHG_MAX_DIV16 = 16;
    // pin synchroniser lanes
    localparam int PIN_X1 = 0;
    localparam int PIN_X2 = 1;
    localparam int PIN_NMI = 2;
    localparam int PIN_IRQ4 = 3;
    localparam int PIN_IRQ5 = 4;
    localparam int PIN_N = 5;

    typedef enum logic [1:0] {RUN, STOPPED, STABILIZE} osc_state_e;

    // oscillator periods per system clock period for a ratio code
    function automatic logic [4:0] div_period(input logic [1:0] ratio);
        div_period = 5'(5'd2 << ratio);
    endfunction
endpackage

/* shared/div_if.sv */
// signals between the clock generator control and its divider
// assumes both ends run on the core clock
`timescale 1ns/1ps
interface div_if;
    logic osc_tick;
    logic [1:0] ratio_req;
    logic [1:0] ratio_cur;
    logic change_busy;
    logic sys_clk;
    logic sys_tick;
    modport ctrl(output osc_tick, output ratio_req, input ratio_cur, input change_busy, input sys_clk,
                 input sys_tick);
    modport div(input osc_tick, input ratio_req, output ratio_cur, output change_busy, output sys_clk,
                output sys_tick);
endinterface

/* test/clock_generator_props.sv */
// assertions on the clock generator top ports
// assumes a bind from the bench with the same stabilization unit
`timescale 1ns/1ps
module clock_generator_props
    import clkgen_pkg::*;
#(
    parameter int STAB_UNIT_CYCLES = STAB_UNIT_CYC
)
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // oscillator and status
    input wire logic OSC_AMP_EN,
    input wire logic SYS_CLK,
    input wire logic SYS_CLK_TICK,
    input wire logic EXT_CLOCK_MODE,
    input wire logic STOP_ACTIVE,
    input wire logic STABILIZING
);
    logic [15:0] stab_cnt_reg;
    logic [15:0] stab_cnt_next;
    always_comb stab_cnt_next = STABILIZING ? stab_cnt_reg + 16'h0001 : 16'h0000;
    always_ff @(posedge CORE_CLK) stab_cnt_reg <= RST_N ? stab_cnt_next : 16'h0000;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    a_tick_on_rise: assert property (SYS_CLK_TICK |-> $rose(SYS_CLK))
        else $error("tick without clock rise");
    a_rise_has_tick: assert property ($rose(SYS_CLK) |-> SYS_CLK_TICK)
        else $error("clock rise without tick");
    a_stop_frozen: assert property (STOP_ACTIVE && $past(STOP_ACTIVE, 2) |-> !SYS_CLK_TICK && $stable(SYS_CLK))
        else $error("clock runs in stop");
    a_amp_ext_off: assert property (EXT_CLOCK_MODE && $past(EXT_CLOCK_MODE) |-> !OSC_AMP_EN)
        else $error("amplifier on in external mode");
    a_amp_stop_off: assert property (STOP_ACTIVE && $past(STOP_ACTIVE) |-> !OSC_AMP_EN)
        else $error("amplifier on in stop");
    a_stab_from_stop: assert property ($rose(STABILIZING) |-> $past(STOP_ACTIVE))
        else $error("stabilizing without stop");
    a_wake_stab: assert property ($fell(STOP_ACTIVE) |-> STABILIZING)
        else $error("wake skipped stabilization");
    a_stab_ext_len: assert property (STABILIZING && EXT_CLOCK_MODE |-> stab_cnt_reg < 16'h0010)
        else $error("external wait too long");
    a_stab_len: assert property (STABILIZING |-> stab_cnt_reg < 16'(STAB_UNIT_CYCLES << 7))
        else $error("stabilization too long");
    a_reset_idle: assert property (disable iff (1'b0) !RST_N |=> !STOP_ACTIVE && !STABILIZING && !EXT_CLOCK_MODE && !SYS_CLK)
        else $error("reset state wrong");
endmodule

/* test/osc_source.sv */
// external clock source: free-running clock on primary, inverse on secondary
// assumes either pin may be held low by the bench to prove which one is used
`timescale 1ns/1ps
module osc_source #(
    parameter int HALF_NS = 20
)
(
    // hold controls
    input wire logic pri_hold,
    input wire logic sec_hold,
    // oscillator pins
    output logic pri,
    output logic sec
);
    logic phase = 1'b0;
    initial begin
        #3;
        forever #(HALF_NS) phase = ~phase;
    end
    assign pri = pri_hold ? 1'b0 : phase;
    assign sec = sec_hold ? 1'b0 : ~phase;
endmodule

/* test/tb.sv */
// self-checking bench for the clock generator
// assumes the oscillator source model and the package constants
`timescale 1ns/1ps
module tb;
    import clkgen_pkg::*;
    typedef struct {logic [1:0] ratio; int gap;} row_s;
    row_s rows [5] = '{'{2'b00, 10}, '{2'b01, 20}, '{2'b10, 40}, '{2'b11, 80}, '{2'b00, 10}};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, pri_hold = 1'b0, sec_hold = 1'b0;
    logic [2:0] wake = 3'h0;
    logic [3:0] msk = 4'h0;
    logic pri, sec, amp_en, sclk, tick, ext_mode, stop, stab, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int cyc = 0, last_t = 0, gap = 0, err_total = 0, comparisons = 0, t0, old;
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (tick) begin
            last_t <= cyc;
            gap <= cyc - last_t;
        end
    end
    clock_generator #(.STAB_UNIT_CYCLES(4)) i_clock_generator (.CORE_CLK(core_clk), .RST_N(rst_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(1'b1), .OSC_INPUT_PRIMARY(pri), .OSC_INPUT_SECONDARY(sec), .OSC_AMP_EN(amp_en),
        .NMI_IN(wake[0]), .EXT_IRQ_FOUR(wake[1]), .EXT_IRQ_FIVE(wake[2]), .IRQ_FOUR_MASKED(msk[0]),
        .IRQ_FOUR_MACRO_SVC(msk[1]), .IRQ_FIVE_MASKED(msk[2]), .IRQ_FIVE_MACRO_SVC(msk[3]), .SYS_CLK(sclk),
        .SYS_CLK_TICK(tick), .EXT_CLOCK_MODE(ext_mode), .STOP_ACTIVE(stop), .STABILIZING(stab));
    osc_source i_osc_source (.pri_hold(pri_hold), .sec_hold(sec_hold), .pri(pri), .sec(sec));
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bound(input int n, input int max);
        if (n >= max) begin
            chk("timeout", 32'h0000_0001, 32'h0000_0000);
            conclude();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bound(n, 40);
        chk("bresp", 32'(bresp), 32'(er));
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (arready && arvalid) arvalid <= 1'b0;
            if (rvalid) break;
        end
        bound(n, 40);
        chk(nm, rdata, exp);
        chk("rresp", 32'(rresp), 32'(er));
    endtask
    task automatic wait_tick();
        int n;
        for (n = 0; n < 400; n++) begin
            @(negedge core_clk);
            if (tick === 1'b1) break;
        end
        bound(n, 400);
        @(negedge core_clk);
        @(posedge core_clk);
    endtask
    task automatic pulse(input int i);
        wake[i] <= 1'b1;
        repeat (4) @(posedge core_clk);
        wake[i] <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic stop_wake(input int src, input int len);
        int n;
        int seen;
        wr(ADDR_STBY, 32'h0000_0002, RESP_OKAY);
        repeat (2) @(posedge core_clk);
        chk("stop", 32'({stop, amp_en}), 32'h0000_0002);
        for (n = 0; n < 4; n++) begin
            msk <= 4'(1 << n);
            pulse(1 + n / 2);
            chk("stop held", 32'(stop), 32'h0000_0001);
        end
        msk <= 4'h0;
        repeat (2) @(posedge core_clk);
        // count only the cycles with stab high after the wake edge, not the synchroniser delay before them
        wake[src] <= 1'b1;
        seen = 0;
        for (n = 0; n < 1000; n++) begin
            @(posedge core_clk);
            if (n == 4) wake[src] <= 1'b0;
            if (stab === 1'b1) seen++;
            else if (seen > 0) break;
        end
        bound(n, 1000);
        chk("stab len", 32'(seen), 32'(len));
        wait_tick();
        chk("run", 32'({stop, amp_en}), 32'(!ext_mode));
    endtask
    function automatic int lim(input int g);
        case (g)
            10: lim = CHG_MAX_DIV2 * 5 + 8;
            20: lim = CHG_MAX_DIV4 * 5 + 8;
            40: lim = CHG_MAX_DIV8 * 5 + 8;
            default: lim = CHG_MAX_DIV16 * 5 + 8;
        endcase
    endfunction
    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        chk("idle", 32'({amp_en, ext_mode, stop, stab}), 32'h0000_0008);
        rdc("stby", ADDR_STBY, 32'(STBY_RESET), RESP_OKAY);
        rdc("stab", ADDR_STAB, 32'(STAB_RESET), RESP_OKAY);
        rdc("unmapped", 8'h0C, 32'h0000_0000, RESP_SLVERR);
        wr(ADDR_STAT, 32'h0000_00FF, RESP_OKAY);
        wr(8'h10, 32'h0000_0001, RESP_SLVERR);
        rdc("status", ADDR_STAT, 32'h0000_0038, RESP_OKAY);
        wait_tick();
        $display("reset values done");
        old = 80;
        foreach (rows[i]) begin
            wr(ADDR_STBY, 32'(rows[i].ratio) << 4, RESP_OKAY);
            t0 = cyc;
            wait_tick();
            chk("old gap", 32'(gap), 32'(old));
            chk("change time", 32'(cyc - t0 <= lim(old)), 32'h0000_0001);
            wait_tick();
            chk("new gap", 32'(gap), 32'(rows[i].gap));
            chk("sys clk high", 32'(sclk), 32'h0000_0001);
            rdc("ratio", ADDR_STAT, 32'h0000_0008 | (32'(rows[i].ratio) << 4), RESP_OKAY);
            old = rows[i].gap;
        end
        $display("ratio table done");
        wr(ADDR_STAB, 32'h0000_0002, RESP_OKAY);
        stop_wake(1, 16);
        wr(ADDR_STAB, 32'h0000_0000, RESP_OKAY);
        stop_wake(2, 4);
        $display("resonator wake done");
        sec_hold <= 1'b1;
        wait_tick();
        wait_tick();
        chk("primary", 32'(gap), 32'h0000_000A);
        wr(ADDR_STAB, 32'h0000_0087, RESP_OKAY);
        sec_hold <= 1'b0;
        pri_hold <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk("ext", 32'({ext_mode, amp_en}), 32'h0000_0002);
        repeat (3) wait_tick();
        chk("secondary", 32'(gap), 32'h0000_000A);
        stop_wake(0, 16);
        $display("external wake done");
        pri_hold <= 1'b0;
        wr(ADDR_STBY, 32'h0000_0002, RESP_OKAY);
        rst_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        chk("reset wake", 32'({stop, stab, ext_mode, amp_en}), 32'h0000_0001);
        rdc("stby", ADDR_STBY, 32'(STBY_RESET), RESP_OKAY);
        // the first oscillator edge after a mid-run reset may be seen early, so skip one period
        repeat (3) wait_tick();
        chk("reset ratio", 32'(gap), 32'h0000_0050);
        $display("reset wake done");
        conclude();
    end
endmodule
bind clock_generator clock_generator_props #(.STAB_UNIT_CYCLES(STAB_UNIT_CYCLES)) i_clock_generator_props (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .OSC_AMP_EN(OSC_AMP_EN), .SYS_CLK(SYS_CLK),
    .SYS_CLK_TICK(SYS_CLK_TICK), .EXT_CLOCK_MODE(EXT_CLOCK_MODE), .STOP_ACTIVE(STOP_ACTIVE),
    .STABILIZING(STABILIZING));
